// ===== hdl/cdt_timer.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Function
// - reset selects single wide up-counter mode
// - four words concatenated, word 3 most significant
// - wide counter steps by one per tick
// - wide match raises interrupt, dma, output
// - pulse style drives pin one to four
// - continuous mode clears counter after match
// - chained upper half prescales lower half
// - prescaler ticks and clears after match
// - lower counts prescaler ticks, match raises events
// - chained mode ignores control register two
// - unchained halves count independently; upper prescale set in control one
// - upper prescaler always uses internal clock
// - small prescaler from two control fields
// - upper counts small ticks, match updates state
// - upper pulse state lasts one to four
// - clock style toggles upper state; pin follows lower only
// - upper governed by control two, global, control one prescale fields
// - lower unchained counts ticks, raises events
// - lower pulse polarity follows invert bit
// - lower ignores control register two
// - global mode field decodes three modes, guard runs as wide
// - once mode stops, continuous keeps counting
module cdt_timer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic match_interrupt,
    output logic match_dma_event,
    output logic timer_pin_out,
    output logic timer_pin_oe_n
);
    import cdt_pkg::*;

    logic [63:0] count_reg;
    logic [63:0] period_reg;
    logic [15:0] control_reg_1;
    logic [15:0] control_reg_2;
    logic [15:0] global_control_1;
    logic [3:0] small_count_reg;
    logic lo_state_reg;
    logic hi_state_reg;
    logic [2:0] lo_pulse_reg;
    logic [2:0] hi_pulse_reg;
    logic lo_wait_reg;
    logic hi_wait_reg;
    logic pre_wait_reg;
    logic small_wait_reg;

    logic [1:0] timer_mode_select;
    logic lower_half_run_bit;
    logic upper_half_run_bit;
    logic [1:0] ena1;
    logic [1:0] ena2;
    logic split;
    logic wide_mode;
    logic chain_mode;
    logic run_lo;
    logic run_hi;
    logic wide_match;
    logic lo_match;
    logic hi_match;
    logic pre_match;
    logic small_match;
    logic lo_hit;
    logic hi_hit;
    logic lo_tick;
    logic hi_tick;
    logic [3:0] small_period;

    function automatic logic [2:0] pulse_len(input logic [1:0] w);
        pulse_len = {1'b0, w} + 3'h1;
    endfunction

    assign timer_mode_select = global_control_1[POS_MODE_LO+:2];
    assign lower_half_run_bit = global_control_1[POS_LOWER_RUN];
    assign upper_half_run_bit = global_control_1[POS_UPPER_RUN];
    assign ena1 = control_reg_1[POS_ENA_LO+:2];
    assign ena2 = control_reg_2[POS_ENA_LO+:2];
    // guard mode is not built here; it behaves as wide
    assign wide_mode = (timer_mode_select == MODE_WIDE) || (timer_mode_select == MODE_GUARD);
    assign chain_mode = timer_mode_select == MODE_CHAINED;
    assign split = timer_mode_select == MODE_UNCHAINED;
    // wide/chained need both run bits; ena2 consulted only for the unchained upper half
    assign run_lo = (ena1 != ENA_OFF) && lower_half_run_bit &&
                    (split || upper_half_run_bit);
    assign run_hi = split ? ((ena2 != ENA_OFF) && upper_half_run_bit) : run_lo;
    assign small_period = control_reg_1[POS_PSC_B_LO+:4];
    assign wide_match = count_reg == period_reg;
    assign lo_match = count_reg[31:0] == period_reg[31:0];
    assign hi_match = count_reg[63:32] == period_reg[63:32];
    assign pre_match = chain_mode && run_lo && hi_match && !pre_wait_reg;
    assign small_match = split && run_hi && (small_count_reg == small_period) && !small_wait_reg;
    assign lo_tick = chain_mode ? pre_wait_reg : 1'b1;
    assign hi_tick = small_wait_reg;
    // a match is taken once; the count wraps at once, the events trail by a cycle
    assign lo_hit = run_lo && lo_tick && !lo_wait_reg &&
                    (wide_mode ? wide_match : lo_match);
    assign hi_hit = split && run_hi && hi_tick && hi_match && !hi_wait_reg;

    // register writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            control_reg_1 <= CTRL_RESET;
            control_reg_2 <= CTRL_RESET;
            global_control_1 <= GLOBAL_RESET;
        end else begin
            if (reg_wr && reg_addr == ADDR_CONTROL_1) begin
                control_reg_1 <= reg_wdata;
            end else if (lo_hit && ena1 == ENA_ONCE) begin
                control_reg_1[POS_ENA_LO+:2] <= ENA_OFF;
            end
            if (reg_wr && reg_addr == ADDR_CONTROL_2) begin
                control_reg_2 <= reg_wdata;
            end else if (hi_hit && ena2 == ENA_ONCE) begin
                control_reg_2[POS_ENA_LO+:2] <= ENA_OFF;
            end
            if (reg_wr && reg_addr == ADDR_GLOBAL_1) begin
                global_control_1 <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            period_reg <= 64'h0;
        end else if (reg_wr && reg_addr[3:2] == 2'h1) begin
            period_reg[{reg_addr[1:0], 4'h0}+:16] <= reg_wdata;
        end
    end

    // match flags and ticks trail the match by one cycle; the events follow a cycle after that
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lo_wait_reg <= 1'b0;
            hi_wait_reg <= 1'b0;
            pre_wait_reg <= 1'b0;
            small_wait_reg <= 1'b0;
        end else begin
            lo_wait_reg <= lo_hit;
            hi_wait_reg <= hi_hit;
            pre_wait_reg <= pre_match;
            small_wait_reg <= small_match;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_reg <= 64'h0;
        end else if (reg_wr && reg_addr[3:2] == 2'h0) begin
            count_reg[{reg_addr[1:0], 4'h0}+:16] <= reg_wdata;
        end else if (wide_mode) begin
            if (lo_hit) begin
                count_reg <= 64'h0;
            end else if (run_lo && !wide_match) begin
                count_reg <= count_reg + 64'h1;
            end
        end else begin
            if (lo_hit) begin
                count_reg[31:0] <= 32'h0;
            end else if (run_lo && lo_tick && !lo_match) begin
                count_reg[31:0] <= count_reg[31:0] + 32'h1;
            end
            if (chain_mode) begin
                if (pre_match) begin
                    count_reg[63:32] <= 32'h0;
                end else if (run_lo && !hi_match) begin
                    count_reg[63:32] <= count_reg[63:32] + 32'h1;
                end
            end else if (hi_hit) begin
                count_reg[63:32] <= 32'h0;
            end else if (run_hi && hi_tick && !hi_match) begin
                count_reg[63:32] <= count_reg[63:32] + 32'h1;
            end
        end
    end

    // small prescaler count starts from field a, wraps at field b
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            small_count_reg <= 4'h0;
        end else if (reg_wr && reg_addr == ADDR_CONTROL_1) begin
            small_count_reg <= reg_wdata[POS_PSC_A_LO+:4];
        end else if (small_match) begin
            small_count_reg <= 4'h0;
        end else if (split && run_hi && small_count_reg != small_period) begin
            small_count_reg <= small_count_reg + 4'h1;
        end
    end

    // output state: pulse counts down, clock style toggles
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !lower_half_run_bit) begin
            lo_state_reg <= 1'b0;
            lo_pulse_reg <= 3'h0;
        end else if (lo_wait_reg) begin
            if (control_reg_1[POS_STYLE]) begin
                lo_state_reg <= !lo_state_reg;
            end else begin
                lo_state_reg <= 1'b1;
                lo_pulse_reg <= pulse_len(control_reg_1[POS_PULSE_WIDTH_FIELD_LO+:2]) - 3'h1;
            end
        end else if (!control_reg_1[POS_STYLE]) begin
            if (lo_pulse_reg != 3'h0) begin
                lo_pulse_reg <= lo_pulse_reg - 3'h1;
            end else begin
                lo_state_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !upper_half_run_bit) begin
            hi_state_reg <= 1'b0;
            hi_pulse_reg <= 3'h0;
        end else if (hi_wait_reg) begin
            if (control_reg_2[POS_STYLE]) begin
                hi_state_reg <= !hi_state_reg;
            end else begin
                hi_state_reg <= 1'b1;
                hi_pulse_reg <= pulse_len(control_reg_2[POS_PULSE_WIDTH_FIELD_LO+:2]) - 3'h1;
            end
        end else if (!control_reg_2[POS_STYLE]) begin
            if (hi_pulse_reg != 3'h0) begin
                hi_pulse_reg <= hi_pulse_reg - 3'h1;
            end else begin
                hi_state_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            match_interrupt <= 1'b0;
            match_dma_event <= 1'b0;
            timer_pin_out <= 1'b0;
            timer_pin_oe_n <= 1'b1;
        end else begin
            match_interrupt <= lo_wait_reg;
            match_dma_event <= lo_wait_reg;
            timer_pin_out <= lo_state_reg ^ control_reg_1[POS_OUT_INV];
            // pin released while lower half held in reset
            timer_pin_oe_n <= !lower_half_run_bit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_COUNT_WORD_0: reg_rdata <= count_reg[15:0];
                ADDR_COUNT_WORD_1: reg_rdata <= count_reg[31:16];
                ADDR_COUNT_WORD_2: reg_rdata <= count_reg[47:32];
                ADDR_COUNT_WORD_3: reg_rdata <= count_reg[63:48];
                ADDR_PERIOD_WORD_0: reg_rdata <= period_reg[15:0];
                ADDR_PERIOD_WORD_1: reg_rdata <= period_reg[31:16];
                ADDR_PERIOD_WORD_2: reg_rdata <= period_reg[47:32];
                ADDR_PERIOD_WORD_3: reg_rdata <= period_reg[63:48];
                ADDR_CONTROL_1: reg_rdata <= {control_reg_1[15:2], lo_state_reg,
                                              control_reg_1[0]};
                ADDR_CONTROL_2: reg_rdata <= {control_reg_2[15:2], hi_state_reg,
                                              control_reg_2[0]};
                ADDR_GLOBAL_1: reg_rdata <= global_control_1;
                default: reg_rdata <= 16'h0;
            endcase
        end else begin
            reg_rdata <= 16'h0;
        end
    end

    chk_reset_wide: assert property (
        @(posedge ref_clk)
        $fell(sys_rst)
        |-> wide_mode)
        else $error("not wide after reset");
    chk_wide_step: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (wide_mode && run_lo && !wide_match && !lo_wait_reg && !reg_wr)
        |=> count_reg == $past(count_reg) + 64'h1)
        else $error("wide counter did not step");
    chk_match_event: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        lo_wait_reg
        |=> match_interrupt && match_dma_event)
        else $error("match events missing");
    chk_clear_after: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (wide_mode && lo_hit && !reg_wr)
        |=> count_reg == 64'h0)
        else $error("counter not cleared");
    chk_pre_clear: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (pre_match && !reg_wr)
        |=> count_reg[63:32] == 32'h0 && pre_wait_reg)
        else $error("prescaler not cleared");
    chk_chain_step: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (chain_mode && run_lo && !hi_match && !reg_wr)
        |=> count_reg[63:32] == $past(count_reg[63:32]) + 32'h1)
        else $error("prescaler did not step");
    chk_lower_tick: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (chain_mode && !pre_wait_reg && !reg_wr)
        |=> count_reg[31:0] == $past(count_reg[31:0]))
        else $error("lower moved without a tick");
    chk_once_stop: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (lo_hit && ena1 == ENA_ONCE && !reg_wr)
        |=> ena1 == ENA_OFF)
        else $error("once mode kept running");
    chk_hi_once: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (hi_hit && ena2 == ENA_ONCE && !reg_wr)
        |=> ena2 == ENA_OFF)
        else $error("upper once mode kept running");
    chk_pulse_min: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (lo_wait_reg && !control_reg_1[POS_STYLE] && lower_half_run_bit && !reg_wr)
        |=> lo_state_reg)
        else $error("pulse not asserted");
    chk_pulse_end: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (lo_state_reg && lo_pulse_reg == 3'h0 && !lo_wait_reg && !control_reg_1[POS_STYLE]
         && lower_half_run_bit && !reg_wr)
        |=> !lo_state_reg)
        else $error("pulse did not end");
    chk_state_reset: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!lower_half_run_bit && !reg_wr)
        |=> !lo_state_reg && timer_pin_oe_n)
        else $error("lower state kept in reset");
    chk_toggle: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (hi_wait_reg && control_reg_2[POS_STYLE] && upper_half_run_bit && !reg_wr)
        |=> hi_state_reg != $past(hi_state_reg))
        else $error("state did not toggle");
    chk_hi_pulse: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (hi_wait_reg && !control_reg_2[POS_STYLE] && upper_half_run_bit && !reg_wr)
        |=> hi_state_reg)
        else $error("upper pulse not asserted");
    chk_chain_ignores: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        chain_mode
        |-> !hi_wait_reg && !small_wait_reg)
        else $error("upper controls active in chain");
    chk_small_clear: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (small_match && !reg_wr)
        |=> small_wait_reg && small_count_reg == 4'h0)
        else $error("small prescaler not cleared");
    chk_upper_step: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (split && !hi_tick && !reg_wr)
        |=> count_reg[63:32] == $past(count_reg[63:32]))
        else $error("upper moved without a tick");
    chk_upper_clear: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (hi_hit && !reg_wr)
        |=> hi_wait_reg && count_reg[63:32] == 32'h0)
        else $error("upper not cleared");
    chk_upper_held: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (split && !run_hi && !reg_wr)
        |=> count_reg[63:32] == $past(count_reg[63:32]))
        else $error("upper ran while disabled");
    chk_lower_alone: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!wide_mode && !run_lo && !reg_wr)
        |=> count_reg[31:0] == $past(count_reg[31:0]))
        else $error("lower ran while disabled");
    cov_wide_match: cover property (@(posedge ref_clk) wide_mode && lo_wait_reg);
    cov_once_stop: cover property (@(posedge ref_clk) lo_hit && ena1 == ENA_ONCE);
    cov_long_pulse: cover property (@(posedge ref_clk) lo_pulse_reg == 3'h3);
    cov_chain_tick: cover property (@(posedge ref_clk) chain_mode && pre_wait_reg);
    cov_split_hi: cover property (@(posedge ref_clk) split && hi_wait_reg);
endmodule
`default_nettype wire

// ===== hdl/cdt_pkg.sv
package cdt_pkg;
    // register offsets (16-bit words)
    localparam logic [3:0] ADDR_COUNT_WORD_0 = 4'h0;
    localparam logic [3:0] ADDR_COUNT_WORD_1 = 4'h1;
    localparam logic [3:0] ADDR_COUNT_WORD_2 = 4'h2;
    localparam logic [3:0] ADDR_COUNT_WORD_3 = 4'h3;
    localparam logic [3:0] ADDR_PERIOD_WORD_0 = 4'h4;
    localparam logic [3:0] ADDR_PERIOD_WORD_1 = 4'h5;
    localparam logic [3:0] ADDR_PERIOD_WORD_2 = 4'h6;
    localparam logic [3:0] ADDR_PERIOD_WORD_3 = 4'h7;
    localparam logic [3:0] ADDR_CONTROL_1 = 4'h8;
    localparam logic [3:0] ADDR_CONTROL_2 = 4'h9;
    localparam logic [3:0] ADDR_GLOBAL_1 = 4'ha;
    // control register fields
    localparam int POS_OUT_INV = 0;
    localparam int POS_STATE = 1;
    localparam int POS_STYLE = 3;
    localparam int POS_PULSE_WIDTH_FIELD_LO = 4;
    localparam int POS_ENA_LO = 6;
    localparam int POS_PSC_A_LO = 8;
    localparam int POS_PSC_B_LO = 12;
    // global control fields
    localparam int POS_LOWER_RUN = 0;
    localparam int POS_UPPER_RUN = 1;
    localparam int POS_MODE_LO = 2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] GLOBAL_RESET = 16'h0000;
    localparam logic [1:0] MODE_WIDE = 2'h0;
    localparam logic [1:0] MODE_UNCHAINED = 2'h1;
    localparam logic [1:0] MODE_GUARD = 2'h2;
    localparam logic [1:0] MODE_CHAINED = 2'h3;
    localparam logic [1:0] ENA_OFF = 2'h0;
    localparam logic [1:0] ENA_ONCE = 2'h1;
    localparam logic [1:0] ENA_CONT = 2'h2;
endpackage

// ===== dv/cdt_event_sink.sv
`timescale 1ns/1ns
`default_nettype none
// stands in for the cpu interrupt input and the dma request line
module cdt_event_sink (
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic match_interrupt,
    input wire logic match_dma_event,
    input wire logic timer_pin_out,
    output int irq_count,
    output int gap,
    output int flips,
    output int split
);
    int age;
    logic pin_seen;
    // pin is only ever watched as an output, never driven here
    always @(posedge ref_clk) begin
        age <= age + 1;
        if (clr) begin
            irq_count <= 0;
            flips <= 0;
            split <= 0;
            gap <= 0;
        end else begin
            if (match_interrupt !== match_dma_event) begin
                split <= split + 1;
            end
            if (match_interrupt === 1'b1) begin
                irq_count <= irq_count + 1;
                gap <= age;
                age <= 1;
                pin_seen <= timer_pin_out;
                if (irq_count > 0 && timer_pin_out !== pin_seen) begin
                    flips <= flips + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/cdt_timer_test.sv
`timescale 1ns/1ns
`default_nettype none
module cdt_timer_test;
    import cdt_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clr = 1'b1;
    logic [15:0] reg_rdata;
    logic match_interrupt, match_dma_event, timer_pin_out, timer_pin_oe_n;
    int irq_count, gap, flips, split;
    int err_total = 0;
    int checks_done = 0;
    int n;

    always #25 ref_clk = ~ref_clk;

    cdt_timer cdt_timer_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .match_interrupt(match_interrupt),
        .match_dma_event(match_dma_event), .timer_pin_out(timer_pin_out),
        .timer_pin_oe_n(timer_pin_oe_n)
    );
    cdt_event_sink cdt_event_sink_i (
        .ref_clk(ref_clk), .clr(clr), .match_interrupt(match_interrupt),
        .match_dma_event(match_dma_event), .timer_pin_out(timer_pin_out),
        .irq_count(irq_count), .gap(gap), .flips(flips), .split(split)
    );

    task automatic close_out;
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk({16'h0000, reg_rdata & m}, {16'h0000, exp});
    endtask

    function automatic logic [15:0] ctl(logic [1:0] e, logic [1:0] w, logic s, logic i);
        return {8'h00, e, w, s, 2'b00, i};
    endfunction

    // zero the count, set lower period word and the prescale word
    task automatic setp(input logic [15:0] p, input logic [15:0] pre);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COUNT_WORD_0 + 4'(i), 16'h0000);
        end
        wr(ADDR_PERIOD_WORD_0, p);
        wr(ADDR_PERIOD_WORD_1, 16'h0000);
        wr(ADDR_PERIOD_WORD_2, pre);
        wr(ADDR_PERIOD_WORD_3, 16'h0000);
    endtask

    // bounded wait on the interrupt count kept by the sink
    task automatic wait_irq(input int k);
        n = 0;
        while (irq_count < k && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        #1 chk(32'(irq_count >= k), 32'h1);
    endtask

    task automatic restart_sink;
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask

    task automatic s_reset;
        for (int a = 0; a < 11; a++) begin
            rd(4'(a), 16'h0000, 16'hffff);
        end
        chk(timer_pin_oe_n, 1'b1);
        wr(4'hb, 16'hffff);
        rd(4'hb, 16'h0000, 16'hffff);
        wr(ADDR_CONTROL_1, 16'h0002);
        rd(ADDR_CONTROL_1, 16'h0000, 16'hffff);
    endtask

    // carry must cross from word 1 into word 2 before the match
    task automatic s_wide_once;
        setp(16'h0001, 16'h0001);
        wr(ADDR_COUNT_WORD_0, 16'hfffe);
        wr(ADDR_COUNT_WORD_1, 16'hffff);
        wr(ADDR_GLOBAL_1, 16'h0003);
        restart_sink();
        wr(ADDR_CONTROL_1, ctl(ENA_ONCE, 2'h0, 1'b0, 1'b0));
        wait_irq(1);
        repeat (20) @(posedge ref_clk);
        #1 chk(irq_count, 1);
        rd(ADDR_COUNT_WORD_0, 16'h0000, 16'hffff);
        rd(ADDR_COUNT_WORD_2, 16'h0000, 16'hffff);
        rd(ADDR_CONTROL_1, 16'h0000, 16'h00c0);
    endtask

    task automatic s_gap(input logic [15:0] g, input logic [15:0] c, input logic [15:0] pre);
        wr(ADDR_CONTROL_1, 16'h0000);
        setp(16'h0002, pre);
        wr(ADDR_GLOBAL_1, g);
        wr(ADDR_CONTROL_2, c);
        restart_sink();
        wr(ADDR_CONTROL_1, ctl(ENA_CONT, 2'h0, 1'b0, 1'b0));
        wait_irq(3);
        chk(split, 0);
    endtask

    task automatic s_pulse;
        wr(ADDR_GLOBAL_1, 16'h0003);
        for (int inv = 0; inv < 2; inv++) begin
            for (int w = 0; w < 4; w++) begin
                wr(ADDR_CONTROL_1, ctl(ENA_OFF, 2'(w), 1'b0, 1'(inv)));
                setp(16'h0002, 16'h0000);
                wr(ADDR_CONTROL_1, ctl(ENA_ONCE, 2'(w), 1'b0, 1'(inv)));
                n = 0;
                repeat (14) begin
                    @(posedge ref_clk);
                    #1 if (timer_pin_out === 1'(~inv)) n++;
                end
                chk(n, w + 1);
                chk(timer_pin_oe_n, 1'b0);
            end
        end
    endtask

    // upper half alone: small prescale period 0, upper period 1, toggle, once
    task automatic s_upper;
        wr(ADDR_CONTROL_1, 16'h0000);
        setp(16'h0002, 16'h0001);
        wr(ADDR_CONTROL_2, ctl(ENA_ONCE, 2'h0, 1'b1, 1'b0));
        wr(ADDR_GLOBAL_1, 16'h0006);
        repeat (20) @(posedge ref_clk);
        rd(ADDR_CONTROL_2, 16'h0002, 16'h00c2);
        rd(ADDR_COUNT_WORD_2, 16'h0000, 16'hffff);
    endtask

    task automatic s_toggle;
        wr(ADDR_CONTROL_1, 16'h0000);
        setp(16'h0002, 16'h0000);
        restart_sink();
        wr(ADDR_CONTROL_1, ctl(ENA_CONT, 2'h0, 1'b1, 1'b0));
        wait_irq(4);
        chk(flips, irq_count - 1);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        clr <= 1'b0;
        s_reset();
        s_wide_once();
        s_gap(16'h0003, 16'h0000, 16'h0000);
        chk(gap, 3);
        s_pulse();
        s_toggle();
        // control two asks for a one-shot; chained mode must not care
        s_gap(16'h000f, ctl(ENA_ONCE, 2'h0, 1'b0, 1'b0), 16'h0001);
        chk(gap, 6);
        s_gap(16'h0005, 16'h0000, 16'h0000);
        chk(gap, 3);
        rd(ADDR_CONTROL_2, 16'h0000, 16'h0002);
        s_upper();
        wr(ADDR_GLOBAL_1, 16'h0000);
        repeat (2) @(posedge ref_clk);
        #1 chk(timer_pin_oe_n, 1'b1);
        close_out();
    end

    // whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
